// *** verilog/rtc_trim_alarm_map.vh ***
// constants for the time-count trim and the two alarm comparators
`ifndef RTC_TRIM_ALARM_MAP_VH
`define RTC_TRIM_ALARM_MAP_VH

`define ADDR_TRIM          4'h7
`define ADDR_WALARM_MIN    4'h8
`define ADDR_WALARM_HOUR   4'h9
`define ADDR_WALARM_DAY    4'hA
`define ADDR_DALARM_MIN    4'hB
`define ADDR_DALARM_HOUR   4'hC

`define MIN_FIELD_MASK     8'h7F
`define HOUR_FIELD_MASK    8'h3F
`define DAY_FIELD_MASK     8'h7F
`define TRIM_FIELD_MASK    8'h7F
`define TRIM_SIGN_BIT      6
`define TRIM_RESET         8'h00
`define ALARM_RESET        8'h00

`define PRESCALE_NOMINAL   16'd32768
`define ADJUST_SEC_00      7'h00
`define ADJUST_SEC_20      7'h20
`define ADJUST_SEC_40      7'h40

`endif

// *** verilog/alarm_compare.v ***
// one alarm comparator: minute, hour and optional day mask
`timescale 1ns/1ns
`default_nettype none
module alarm_compare (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       clkEn,
  input  wire       minuteTick,
  input  wire       useDay,
  input  wire [6:0] alarmMin,
  input  wire [5:0] alarmHour,
  input  wire [6:0] dayMask,
  input  wire [6:0] curMin,
  input  wire [5:0] curHour,
  input  wire [2:0] curDay,
  output reg        match_reg
);
  wire dayHit;
  wire allHit;

  // mask bit n selects counter value n; 111 never hits, empty mask never hits
  assign dayHit = (curDay == 3'h7) ? 1'b0 : dayMask[curDay];
  assign allHit = (alarmMin == curMin) && (alarmHour == curHour) && (!useDay || dayHit);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      match_reg <= 1'b0;
    end else if (clkEn) begin
      if (minuteTick) begin
        match_reg <= allHit;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/rtc_trim_alarm.v ***
// time-count trim and weekly/daily alarm registers of the serial clock
//
// Summary of operation
// - sign 0, magnitude 7: adjusted seconds last 32780 pulses.
// - sign 0, magnitude 1: adjusted seconds stay at 32768 pulses.
// - sign 1, magnitude 111110: adjusted seconds last 32764 pulses.
// - each step moves two pulses per 20 seconds, about 3ppm.
// - trim changes pulse count only, never the oscillator or clock output.
// - weekly minute register at 8h, bits 6..0, bit 7 reads 0.
// - weekly hour register at 9h, bits 5..0, bit 5 pm or twenties.
// - weekly day mask at Ah, bits 6..0, bit 7 reads 0.
// - day mask bit n matches day counter value n.
// - empty day mask never gives a weekly match.
// - twelve-hour midnight is 12 and noon 32, as the hour counter.
// - daily minute register at Bh, bits 6..0, bit 7 reads 0.
// - daily hour register at Ch, bits 5..0, bits 7..6 read 0.
// - alarm contents are undefined after the halt flag sets.
// - sign 0 adds (mag-1)*2 pulses; sign 1 removes (~mag+1)*2.
// - untrimmed, seconds advance every 32768 crystal pulses.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_trim_alarm_map.vh"
module rtc_trim_alarm #(
  parameter PRESCALE_WIDTH = 16
) (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       clkEn,
  input  wire       xtalTick,
  input  wire       haltFlag,
  input  wire       regWrite,
  input  wire [3:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire [6:0] curSec,
  input  wire [6:0] curMin,
  input  wire [5:0] curHour,
  input  wire [2:0] curDay,
  input  wire       minuteTick,
  input  wire       weeklyEnable,
  input  wire       dailyEnable,
  output reg  [7:0] regRdata_reg,
  output reg        secondTick_reg,
  output reg        xtalOut_reg,
  output wire       weeklyMatch_reg,
  output wire       dailyMatch_reg
);
  // ************************************************************
  // input synchronisers for the crystal tick and the halt flag
  // ************************************************************
  reg xtalMeta_reg;
  reg xtalSync_reg;
  reg xtalPrev_reg;
  reg haltMeta_reg;
  reg haltSync_reg;
  wire xtalEdge;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      xtalMeta_reg <= 1'b0;
      xtalSync_reg <= 1'b0;
      xtalPrev_reg <= 1'b0;
      haltMeta_reg <= 1'b1;
      haltSync_reg <= 1'b1;
    end else if (clkEn) begin
      xtalMeta_reg <= xtalTick;
      xtalSync_reg <= xtalMeta_reg;
      xtalPrev_reg <= xtalSync_reg;
      haltMeta_reg <= haltFlag;
      haltSync_reg <= haltMeta_reg;
    end
  end

  assign xtalEdge = xtalSync_reg & ~xtalPrev_reg;

  // ************************************************************
  // registers
  // ************************************************************
  // field constants held as full bytes and cut to each register's width below
  localparam [7:0] TRIM_RST  = `TRIM_RESET;
  localparam [7:0] ALARM_RST = `ALARM_RESET;
  localparam [7:0] TRIM_MASK = `TRIM_FIELD_MASK;
  localparam [7:0] MIN_MASK  = `MIN_FIELD_MASK;
  localparam [7:0] HOUR_MASK = `HOUR_FIELD_MASK;
  localparam [7:0] DAY_MASK  = `DAY_FIELD_MASK;

  // strobes and next values are combinational; only the _reg words hold state
  reg  [6:0] trim_reg;
  reg  [6:0] trim_next;
  reg  [6:0] wMin_reg;
  reg  [6:0] wMin_next;
  reg  [5:0] wHour_reg;
  reg  [5:0] wHour_next;
  reg  [6:0] wDay_reg;
  reg  [6:0] wDay_next;
  reg  [6:0] dMin_reg;
  reg  [6:0] dMin_next;
  reg  [5:0] dHour_reg;
  reg  [5:0] dHour_next;

  // set by a trim write that lands in an adjustment second
  reg        trimFresh_reg;

  reg        trimWrite;
  reg        wMinWrite;
  reg        wHourWrite;
  reg        wDayWrite;
  reg        dMinWrite;
  reg        dHourWrite;

  // one strobe per register; writes to unmapped addresses fall through unused
  // addresses below the trim register belong to the counters outside this block
  always @* begin
    trimWrite  = 1'b0;
    wMinWrite  = 1'b0;
    wHourWrite = 1'b0;
    wDayWrite  = 1'b0;
    dMinWrite  = 1'b0;
    dHourWrite = 1'b0;
    if (regWrite) begin
      if (regAddr == `ADDR_TRIM) begin
        trimWrite = 1'b1;
      end else if (regAddr == `ADDR_WALARM_MIN) begin
        wMinWrite = 1'b1;
      end else if (regAddr == `ADDR_WALARM_HOUR) begin
        wHourWrite = 1'b1;
      end else if (regAddr == `ADDR_WALARM_DAY) begin
        wDayWrite = 1'b1;
      end else if (regAddr == `ADDR_DALARM_MIN) begin
        dMinWrite = 1'b1;
      end else if (regAddr == `ADDR_DALARM_HOUR) begin
        dHourWrite = 1'b1;
      end
    end
  end

  // halt beats a write in the same cycle, so a stale trim never outlives a restart
  // limitation: a write refused during a halt is lost, not queued
  always @* begin
    trim_next = trim_reg;
    if (haltSync_reg) begin
      trim_next = TRIM_RST[6:0];
    end else if (trimWrite) begin
      trim_next = regWdata[6:0] & TRIM_MASK[6:0];
    end
  end

  // alarm bytes ignore the halt flag; the host must rewrite them after a halt
  always @* begin
    wMin_next = wMin_reg;
    if (wMinWrite) begin
      wMin_next = regWdata[6:0] & MIN_MASK[6:0];
    end
  end

  always @* begin
    wHour_next = wHour_reg;
    if (wHourWrite) begin
      wHour_next = regWdata[5:0] & HOUR_MASK[5:0];
    end
  end

  // bit 7 of the day mask has no store and always reads zero
  always @* begin
    wDay_next = wDay_reg;
    if (wDayWrite) begin
      wDay_next = regWdata[6:0] & DAY_MASK[6:0];
    end
  end

  always @* begin
    dMin_next = dMin_reg;
    if (dMinWrite) begin
      dMin_next = regWdata[6:0] & MIN_MASK[6:0];
    end
  end

  always @* begin
    dHour_next = dHour_reg;
    if (dHourWrite) begin
      dHour_next = regWdata[5:0] & HOUR_MASK[5:0];
    end
  end

  // every register freezes with the clock enable
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trim_reg <= TRIM_RST[6:0];
    end else if (clkEn) begin
      trim_reg <= trim_next;
    end
  end

  // no write protection: any alarm byte may be rewritten at any time
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wMin_reg  <= ALARM_RST[6:0];
      wHour_reg <= ALARM_RST[5:0];
      wDay_reg  <= ALARM_RST[6:0];
      dMin_reg  <= ALARM_RST[6:0];
      dHour_reg <= ALARM_RST[5:0];
    end else if (clkEn) begin
      wMin_reg  <= wMin_next;
      wHour_reg <= wHour_next;
      wDay_reg  <= wDay_next;
      dMin_reg  <= dMin_next;
      dHour_reg <= dHour_next;
    end
  end

  // ************************************************************
  // read data, unused bits read zero
  // ************************************************************
  reg [7:0] rdata_next;

  always @* begin
    if (regAddr == `ADDR_TRIM) begin
      rdata_next = {1'b0, trim_reg};
    end else if (regAddr == `ADDR_WALARM_MIN) begin
      rdata_next = {1'b0, wMin_reg};
    end else if (regAddr == `ADDR_WALARM_HOUR) begin
      rdata_next = {2'b00, wHour_reg};
    end else if (regAddr == `ADDR_WALARM_DAY) begin
      rdata_next = {1'b0, wDay_reg};
    end else if (regAddr == `ADDR_DALARM_MIN) begin
      rdata_next = {1'b0, dMin_reg};
    end else if (regAddr == `ADDR_DALARM_HOUR) begin
      rdata_next = {2'b00, dHour_reg};
    end else begin
      rdata_next = 8'h00;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_reg <= 8'h00;
    end else if (clkEn) begin
      regRdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // prescale length per second
  // ************************************************************
  wire                      adjustSec;
  wire [5:0]                trimMag;
  wire [6:0]                addPulses;
  wire [6:0]                subPulses;
  reg  [PRESCALE_WIDTH-1:0] secLength;
  reg  [PRESCALE_WIDTH-1:0] presc_reg;
  reg  [6:0]                lastSec_reg;
  wire                      trimActive;

  assign adjustSec = (curSec == `ADJUST_SEC_00) || (curSec == `ADJUST_SEC_20) ||
                     (curSec == `ADJUST_SEC_40);
  assign trimMag   = trim_reg[5:0];
  // one step is two pulses per 20 s, roughly 3ppm
  assign addPulses = {trimMag - 6'h01, 1'b0};
  assign subPulses = {(~trimMag) + 6'h01, 1'b0};
  // magnitude zero means no change either sign; fresh write skips this point
  assign trimActive = adjustSec && !trimFresh_reg && (trimMag != 6'h00);

  always @* begin
    secLength = `PRESCALE_NOMINAL;
    if (trimActive) begin
      if (!trim_reg[`TRIM_SIGN_BIT]) begin
        secLength = `PRESCALE_NOMINAL + {{(PRESCALE_WIDTH-7){1'b0}}, addPulses};
      end else begin
        secLength = `PRESCALE_NOMINAL - {{(PRESCALE_WIDTH-7){1'b0}}, subPulses};
      end
    end
  end

  // trim write marks the current adjustment second as untouched
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trimFresh_reg <= 1'b0;
      lastSec_reg   <= 7'h00;
    end else if (clkEn) begin
      lastSec_reg <= curSec;
      if (trimWrite && adjustSec) begin
        trimFresh_reg <= 1'b1;
      end else if (curSec != lastSec_reg) begin
        trimFresh_reg <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      presc_reg      <= {PRESCALE_WIDTH{1'b0}};
      secondTick_reg <= 1'b0;
      xtalOut_reg    <= 1'b0;
    end else if (clkEn) begin
      // clock output follows the crystal untouched by trim
      xtalOut_reg    <= xtalSync_reg;
      secondTick_reg <= 1'b0;
      if (xtalEdge) begin
        if (presc_reg >= secLength - {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1}) begin
          presc_reg      <= {PRESCALE_WIDTH{1'b0}};
          secondTick_reg <= 1'b1;
        end else begin
          presc_reg <= presc_reg + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ************************************************************
  // alarm comparators
  // ************************************************************
  alarm_compare weeklyAlarm (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .clkEn      (clkEn),
    .minuteTick (minuteTick & weeklyEnable),
    .useDay     (1'b1),
    .alarmMin   (wMin_reg),
    .alarmHour  (wHour_reg),
    .dayMask    (wDay_reg),
    .curMin     (curMin),
    .curHour    (curHour),
    .curDay     (curDay),
    .match_reg  (weeklyMatch_reg)
  );

  alarm_compare dailyAlarm (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .clkEn      (clkEn),
    .minuteTick (minuteTick & dailyEnable),
    .useDay     (1'b0),
    .alarmMin   (dMin_reg),
    .alarmHour  (dHour_reg),
    .dayMask    (7'h00),
    .curMin     (curMin),
    .curHour    (curHour),
    .curDay     (curDay),
    .match_reg  (dailyMatch_reg)
  );
endmodule
`default_nettype wire

// *** verification/rtc_trim_alarm_monitor.sv ***
// assertion checker on the trim and alarm block ports
`timescale 1ns/1ns
`default_nettype none
module rtc_trim_alarm_monitor (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       clkEn,
  input wire logic       xtalTick,
  input wire logic       regWrite,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [6:0] curMin,
  input wire logic [5:0] curHour,
  input wire logic [2:0] curDay,
  input wire logic       minuteTick,
  input wire logic       weeklyEnable,
  input wire logic       dailyEnable,
  input wire logic [7:0] regRdata_reg,
  input wire logic       xtalOut_reg,
  input wire logic       weeklyMatch_reg,
  input wire logic       dailyMatch_reg
);
  // alarm bytes as last written while the clock enable was high
  logic [7:0] sh [16];
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) sh <= '{default: 8'h00};
    else if (regWrite && clkEn) sh[regAddr] <= regWdata;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_top; regAddr inside {4'h8, 4'hA, 4'hB} |=> !regRdata_reg[7]; endproperty
  a_top: assert property (p_top) else $error("bit 7 set");
  property p_hr; regAddr inside {4'h9, 4'hC} |=> regRdata_reg[7:6] == 2'b00; endproperty
  a_hr: assert property (p_hr) else $error("hour top bits");
  property p_wr; regWrite && clkEn && regAddr inside {4'h8, 4'hA, 4'hB} ##1 !regWrite && clkEn && $stable(regAddr)
    |=> regRdata_reg == {1'b0, $past(regWdata[6:0], 2)}; endproperty
  a_wr: assert property (p_wr) else $error("readback");
  property p_wk; minuteTick && clkEn && weeklyEnable |=> weeklyMatch_reg == $past(curMin == sh[8][6:0]
    && curHour == sh[9][5:0] && curDay != 3'h7 && sh[10][curDay]); endproperty
  a_wk: assert property (p_wk) else $error("weekly match");
  property p_dy; minuteTick && clkEn && dailyEnable |=> dailyMatch_reg == $past(curMin == sh[11][6:0]
    && curHour == sh[12][5:0]); endproperty
  a_dy: assert property (p_dy) else $error("daily match");
  property p_none; minuteTick && weeklyEnable && sh[10][6:0] == 7'h00 |=> !weeklyMatch_reg; endproperty
  a_none: assert property (p_none) else $error("empty mask hit");
  property p_hold; !minuteTick |=> $stable(weeklyMatch_reg) && $stable(dailyMatch_reg); endproperty
  a_hold: assert property (p_hold) else $error("match moved");
  property p_xo; xtalOut_reg == $past(xtalTick, 3); endproperty
  a_xo: assert property (p_xo) else $error("clock copy");
endmodule
bind rtc_trim_alarm rtc_trim_alarm_monitor mon (.*);
`default_nettype wire

// *** verification/host_model.sv ***
// host processor model on the register port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] regRdata_reg,
  output var  logic       regWrite = 1'b0,
  output var  logic [3:0] regAddr = 4'h0,
  output var  logic [7:0] regWdata = 8'h00
);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    // released data must not look valid
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    repeat (2) @(posedge sys_clk);
    d = regRdata_reg;
  endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the trim and alarm block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       sys_clk = 0, nrst = 0, xtalTick = 0, haltFlag = 0, minuteTick = 0;
  logic       weeklyEnable = 0, dailyEnable = 0, ew = 0, ed = 0, clkEn = 1;
  logic [6:0] curSec = 0, curMin = 0;
  logic [5:0] curHour = 0;
  logic [2:0] curDay = 0;
  logic [7:0] rd, wm, wh, wd;
  wire        regWrite, secondTick_reg, xtalOut_reg, weeklyMatch_reg, dailyMatch_reg;
  wire  [3:0] regAddr;
  wire  [7:0] regWdata, regRdata_reg;
  integer     failures = 0, n_compared = 0, ticks = 0, seed = 32'h8F638E48, i;
  host_model host (.*);
  rtc_trim_alarm uut (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (secondTick_reg === 1'b1) ticks++;
  task automatic check(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulses(input integer n);
    repeat (n) begin
      @(posedge sys_clk) xtalTick <= 1'b1;
      @(posedge sys_clk) xtalTick <= 1'b0;
    end
    repeat (6) @(negedge sys_clk);
  endtask
  function automatic logic hit(input logic en, old, input logic day);
    return en ? curMin == wm[6:0] && curHour == wh[5:0] && day : old;
  endfunction
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // tests need about 66k cycles
  initial begin
    #(80000 * 40);
    failures++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 7; i < 14; i++) begin
      host.wr(i[3:0], 8'hFF);
      host.rd(i[3:0], rd);
      check(rd, i == 9 || i == 12 ? 8'h3F : i == 13 ? 8'h00 : 8'h7F);
    end
    $display("regs done");
    for (i = 0; i < 40; i++) begin
      wm = 8'({$random(seed)} % 6 * 16 + {$random(seed)} % 10);
      wh = i % 4 == 0 ? 8'h32 : i % 4 == 1 ? 8'h12 : 8'({$random(seed)} % 3 * 16 + {$random(seed)} % 4);
      wd = i % 5 == 0 ? 8'h00 : 8'($random(seed)) & 8'h7F;
      host.wr(4'h8, wm);
      host.wr(4'h9, wh);
      host.wr(4'hA, wd);
      host.wr(4'hB, wm);
      host.wr(4'hC, wh);
      curMin <= i % 3 ? wm[6:0] : wm[6:0] ^ 7'h01;
      curHour <= wh[5:0];
      curDay <= 3'({$random(seed)} % 7);
      weeklyEnable <= i % 4 != 3;
      dailyEnable <= 1'($random(seed));
      minuteTick <= 1'b1;
      @(posedge sys_clk);
      minuteTick <= 1'b0;
      @(posedge sys_clk);
      ew = hit(weeklyEnable, ew, wd[curDay]);
      ed = hit(dailyEnable, ed, 1'b1);
      check({7'h0, weeklyMatch_reg}, {7'h0, ew});
      check({7'h0, dailyMatch_reg}, {7'h0, ed});
    end
    $display("alarms done");
    // a write while the clock enable is low must be lost
    clkEn <= 1'b0;
    host.wr(4'hB, wm ^ 8'h01);
    clkEn <= 1'b1;
    host.rd(4'hB, rd);
    check(rd, {1'b0, wm[6:0]});
    // halt clears trim and refuses trim writes until it has left the synchroniser
    haltFlag <= 1'b1;
    repeat (3) @(posedge sys_clk);
    host.wr(4'h7, 8'h05);
    haltFlag <= 1'b0;
    repeat (3) @(posedge sys_clk);
    host.rd(4'h7, rd);
    check(rd, 8'h00);
    $display("halt and hold done");
    curSec <= 7'h05;
    host.wr(4'h7, 8'h07);
    curSec <= 7'h00;
    pulses(32779);
    check(8'(ticks), 8'h00);
    pulses(1);
    check(8'(ticks), 8'h01);
    $display("trim done");
    complete_run();
  end
endmodule
`default_nettype wire
